/* File: logic/mmf_backoff.sv */
// backoff counter with optional carrier hold and interframe guard
// assumes carrier and load inputs are synchronous to core_clk
`timescale 1ns/100ps
module mmf_backoff
    import mmf_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic holdEn,
    input wire logic carrier,
    input wire logic rate100,
    input wire logic loadValid,
    input wire logic [mmf_pkg::BO_W-1:0] loadSlots,
    output logic expired
);
    // packed state of the counter
    typedef struct packed {
        logic [BO_W-1:0] count;
        logic [HOLD_W-1:0] guard;
        logic exp;
    } mmf_bo_t;
    mmf_bo_t st_q, st_d;
    logic [HOLD_W-1:0] guardLoad;
    assign guardLoad = rate100 ? HOLD_W'(HOLD100_CYC) : HOLD_W'(HOLD10_CYC);

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        if (loadValid) begin
            st_d.count = loadSlots;
            st_d.exp = 1'b0;
        end else if (holdEn && carrier) begin
            st_d.guard = guardLoad;
        end else if (holdEn && st_q.guard != '0) begin
            st_d.guard = st_q.guard - HOLD_W'(1);
        end else if (st_q.count != '0) begin
            st_d.count = st_q.count - BO_W'(1);
        end
        if (!holdEn)
            st_d.guard = '0;
        st_d.exp = (st_d.count == '0) && (st_d.guard == '0) && !(holdEn && carrier);
    end

    // register the state
    always_ff @(posedge core_clk) begin
        if (srst)
            st_q <= '{count: '0, guard: '0, exp: 1'b1};
        else
            st_q <= st_d;
    end
    assign expired = st_q.exp;
endmodule

/* File: logic/mmf_mode_ctrl.sv */
// operating mode register, loopback and duplex steering, receive filter decision
// assumes a strobe register port and frame start/end pulses from the receiver
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module mmf_mode_ctrl
    import mmf_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic symPort,
    input wire logic rate100,
    input wire logic txReq,
    input wire logic miiTxEnRaw,
    output logic miiTxEn,
    output logic txGo,
    output logic heartbeatCheckEn,
    input wire logic carrier,
    input wire logic rxActive,
    input wire logic backoffLoad,
    input wire logic [mmf_pkg::BO_W-1:0] backoffSlots,
    input wire logic rxStart,
    input wire logic addrValid,
    input wire logic [47:0] rxDestAddr,
    input wire logic perfectHit,
    input wire logic hashHit,
    input wire logic rxEnd,
    input wire logic rxBad,
    output logic rxAccept,
    output logic rxDeliver,
    output logic rxDiscard
);
    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [31:0] mode;
        logic invF;
        logic hashOnly;
        logic hashPerf;
        logic [4:0] snap;       // promisc, mcast, badf, inv, honly
        logic snapHp;
        logic passAddr;
        mmf_fstate_t fst;
        logic [31:0] rd;
        logic acc;
        logic dlv;
        logic dsc;
        logic [15:0] okCnt;
        logic [15:0] dropCnt;
    } mmf_st_t;
    mmf_st_t st_q, st_d;
    logic boExpired;

    // decide whether an address passes, given sampled modes
    function automatic logic addrPass(input logic [4:0] s, input logic hp,
                                      input logic [47:0] da, input logic ph,
                                      input logic hh);
        logic grp;
        logic hit;
        grp = da[0];
        hit = hp ? (grp ? hh : (s[0] ? hh : ph)) : ph;
        if (hp && s[0])
            hit = hh;
        if (s[1] && !hp)
            hit = !ph;
        if (s[3] && grp)
            hit = 1'b1;
        if (s[4])
            hit = 1'b1;
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // backoff counter
    mmf_backoff uBackoff (
        .core_clk(core_clk),
        .srst(srst),
        .holdEn(st_q.mode[BOHOLD_BIT]),
        .carrier(carrier),
        .rate100(rate100),
        .loadValid(backoffLoad),
        .loadSlots(backoffSlots),
        .expired(boExpired)
    );

    ////////////////////////////////////////////////////////////////////
    // outputs steered by the mode register
    logic [1:0] loopSel;
    logic duplex;
    assign loopSel = st_q.mode[LOOP_LO+1:LOOP_LO];
    assign duplex = st_q.mode[DUPLEX_BIT];
    // mii loopback gates tx enable, symbol port still drives
    assign miiTxEn = miiTxEnRaw && !(loopSel == LOOP_INTERNAL && !symPort);
    assign txGo = txReq && boExpired && (duplex || !rxActive);
    assign heartbeatCheckEn = !duplex;
    assign regRdData = st_q.rd;
    assign rxAccept = st_q.acc;
    assign rxDeliver = st_q.dlv;
    assign rxDiscard = st_q.dsc;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        st_d.acc = 1'b0;
        st_d.dlv = 1'b0;
        st_d.dsc = 1'b0;
        st_d.rd = '0;
        // register writes
        if (regWr) begin
            if (regAddr == OPMODE_ADDR) begin
                st_d.mode = regWrData;
                st_d.mode[RSVD_BIT] = 1'b0;
                st_d.mode[INVF_BIT] = st_q.invF;
                st_d.mode[HONLY_BIT] = st_q.hashOnly;
                st_d.mode[HPSEL_BIT] = st_q.hashPerf;
            end else if (regAddr == FILTSET_ADDR) begin
                // setup logic loads the read-only filter modes here
                st_d.invF = regWrData[FS_INV_BIT];
                st_d.hashOnly = regWrData[FS_HO_BIT];
                st_d.hashPerf = regWrData[FS_HP_BIT];
            end
        end
        st_d.mode[INVF_BIT] = st_d.invF;
        st_d.mode[HONLY_BIT] = st_d.hashOnly;
        st_d.mode[HPSEL_BIT] = st_d.hashPerf;
        // register reads, answer one cycle later
        if (regRd) begin
            if (regAddr == OPMODE_ADDR)
                st_d.rd = st_q.mode;
            else if (regAddr == FILTSET_ADDR)
                st_d.rd = {29'h0, st_q.hashPerf, st_q.hashOnly, st_q.invF};
            else if (regAddr == STATUS_ADDR)
                st_d.rd = {st_q.dropCnt, st_q.okCnt};
            else
                st_d.rd = 32'h0000_0000;
        end
        // receive filter state machine
        case (st_q.fst)
            MMF_IDLE: begin
                if (rxStart) begin
                    st_d.snap = {st_q.mode[PROMISC_BIT], st_q.mode[MCAST_BIT],
                                 st_q.mode[BADF_BIT], st_q.mode[INVF_BIT],
                                 st_q.mode[HONLY_BIT]};
                    st_d.snapHp = st_q.mode[HPSEL_BIT];
                    st_d.fst = MMF_DECIDE;
                end
            end
            MMF_DECIDE: begin
                if (addrValid) begin
                    st_d.passAddr = addrPass(st_q.snap, st_q.snapHp, rxDestAddr,
                                             perfectHit, hashHit);
                    st_d.acc = st_d.passAddr;
                    st_d.fst = MMF_HOLD;
                end else if (rxEnd) begin
                    // runt ended before the address: only promiscuous keeps it
                    st_d.passAddr = st_q.snap[4];
                    st_d.fst = MMF_HOLD;
                end
            end
            MMF_HOLD: begin
                if (rxEnd) begin
                    if (st_q.passAddr && (!rxBad || st_q.snap[2])) begin
                        st_d.dlv = 1'b1;
                        st_d.okCnt = st_q.okCnt + 16'h0001;
                    end else begin
                        st_d.dsc = 1'b1;
                        st_d.dropCnt = st_q.dropCnt + 16'h0001;
                    end
                    st_d.fst = MMF_IDLE;
                end
            end
            default: st_d.fst = MMF_IDLE;
        endcase
        // a frame ending in the decide cycle resolves straight away
        if (st_q.fst == MMF_DECIDE && rxEnd) begin
            if (st_d.passAddr && (!rxBad || st_q.snap[2])) begin
                st_d.dlv = 1'b1;
                st_d.okCnt = st_q.okCnt + 16'h0001;
            end else begin
                st_d.dsc = 1'b1;
                st_d.dropCnt = st_q.dropCnt + 16'h0001;
            end
            st_d.fst = MMF_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register the state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.mode <= OPMODE_RESET;
            st_q.fst <= MMF_IDLE;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

/* File: logic/mmf_pkg.sv */
// constants for the operating mode and receive filter control block
// assumes a 25 MHz core clock and a plain strobe register port
package mmf_pkg;
    // register map (index chosen locally, byte address is index times four)
    localparam logic [7:0] OPMODE_ADDR = 8'h00;
    localparam logic [7:0] FILTSET_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    // operating mode field positions
    localparam int LOOP_LO = 10;
    localparam int DUPLEX_BIT = 9;
    localparam int RSVD_BIT = 8;
    localparam int MCAST_BIT = 7;
    localparam int PROMISC_BIT = 6;
    localparam int BOHOLD_BIT = 5;
    localparam int INVF_BIT = 4;
    localparam int BADF_BIT = 3;
    localparam int HONLY_BIT = 2;
    localparam int HPSEL_BIT = 0;
    // filter setup register: read-only mode bits loaded from setup logic
    localparam int FS_INV_BIT = 0;
    localparam int FS_HO_BIT = 1;
    localparam int FS_HP_BIT = 2;
    // loopback codes
    localparam logic [1:0] LOOP_NORMAL = 2'h0;
    localparam logic [1:0] LOOP_INTERNAL = 2'h1;
    localparam logic [1:0] LOOP_EXTERNAL = 2'h2;
    // reset value: promiscuous on
    localparam logic [31:0] OPMODE_RESET = 32'h0000_0040;
    // interframe hold after carrier drop
    localparam real CORE_CLK_NS = 40.0;
    localparam real HOLD10_NS = 9600.0;
    localparam real HOLD100_NS = 960.0;
    localparam int HOLD10_CYC = int'($ceil(HOLD10_NS / CORE_CLK_NS));
    localparam int HOLD100_CYC = int'($ceil(HOLD100_NS / CORE_CLK_NS));
    localparam int HOLD_W = 9;
    localparam int BO_W = 10;
    // state of the frame filter sampler
    typedef enum logic [1:0] {MMF_IDLE, MMF_DECIDE, MMF_HOLD} mmf_fstate_t;
endpackage

/* File: verification/mmf_medium.sv */
// network medium model: carrier and receive frames
// assumes the bench calls its tasks; all changes follow core_clk
`timescale 1ns/100ps
module mmf_medium (
    input wire logic core_clk,
    output logic carrier, rxActive, rxStart, addrValid, perfectHit, hashHit, rxEnd, rxBad,
    output logic [47:0] rxDestAddr
);
    initial begin
        {carrier, rxActive, rxStart, addrValid, perfectHit, hashHit, rxEnd, rxBad} = 8'h00;
        rxDestAddr = 48'h0;
    end
    // carrier for n cycles, optionally with receive activity
    task automatic busy(input int n, input logic act);
        @(posedge core_clk) {carrier, rxActive} <= {1'b1, act};
        repeat (n) @(posedge core_clk);
        {carrier, rxActive} <= 2'h0;
    endtask
    // one frame; released lines flip so stale values never look valid
    task automatic frame(input logic g, ph, hh, bad);
        @(posedge core_clk) {carrier, rxActive, rxStart} <= 3'h7;
        @(posedge core_clk) rxStart <= 1'b0;
        @(posedge core_clk) {addrValid, perfectHit, hashHit} <= {1'b1, ph, hh};
        rxDestAddr <= {47'h1234_5678_9ABC, g};
        @(posedge core_clk) {addrValid, perfectHit, hashHit} <= {1'b0, ~ph, ~hh};
        rxDestAddr <= ~rxDestAddr;
        repeat (2) @(posedge core_clk);
        {rxEnd, rxBad} <= {1'b1, bad};
        @(posedge core_clk) {rxEnd, rxBad, carrier, rxActive} <= {1'b0, ~bad, 2'h0};
    endtask
endmodule

/* File: verification/mmf_mode_ctrl_sva.sv */
// port checker for the mode control block
// assumes one core_clk domain, srst synchronous high
`timescale 1ns/100ps
module mmf_mode_ctrl_sva
    import mmf_pkg::*;
(
    input wire logic core_clk, srst, regWr, regRd, symPort, rate100, txReq,
    input wire logic miiTxEnRaw, miiTxEn, txGo, heartbeatCheckEn, carrier, rxActive,
    input wire logic rxStart, addrValid, rxEnd, rxAccept, rxDeliver, rxDiscard,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData, regRdData
);
    import mmf_pkg::*;
    logic [31:0] modeQ; // shadow of the mode register
    logic promQ; // promiscuous bit latched at frame start
    logic [7:0] quietQ; // cycles since carrier low, saturating
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    // shadow state; quiet count saturates so long idle never wraps
    always_ff @(posedge core_clk) begin
        if (srst) begin
            modeQ <= OPMODE_RESET;
            promQ <= 1'b1;
            quietQ <= 8'hFF;
        end else begin
            if (regWr && regAddr == OPMODE_ADDR) modeQ <= regWrData;
            if (rxStart) promQ <= modeQ[PROMISC_BIT];
            quietQ <= carrier ? 8'h00 : (quietQ == 8'hFF ? quietQ : quietQ + 8'h01);
        end
    end
    loop_mask_a: assert property (miiTxEn == (miiTxEnRaw &&
        !(modeQ[11:10] == LOOP_INTERNAL && !symPort))) else $error("transmit enable wrong");
    hbeat_off_a: assert property (heartbeatCheckEn != modeQ[DUPLEX_BIT])
        else $error("heartbeat check wrong");
    duplex_go_a: assert property (txGo |-> txReq && (modeQ[DUPLEX_BIT] || !rxActive))
        else $error("transmit start while receiving");
    mode_read_a: assert property (regRd && regAddr == OPMODE_ADDR |=>
        regRdData[11:5] == {$past(modeQ[11:9]), 1'b0, $past(modeQ[7:5])})
        else $error("mode readback wrong");
    read_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside slot");
    accept_cause_a: assert property (rxAccept |-> $past(addrValid))
        else $error("accept without address");
    promisc_acc_a: assert property (addrValid && promQ |=> rxAccept)
        else $error("promiscuous frame refused");
    end_answer_a: assert property (rxEnd |=> rxDeliver ^ rxDiscard)
        else $error("frame end answer wrong");
    guard_time_a: assert property (txGo && modeQ[BOHOLD_BIT] && !carrier |->
        quietQ >= (rate100 ? 8'(HOLD100_CYC) : 8'(HOLD10_CYC))) else $error("guard time broken");
endmodule
bind mmf_mode_ctrl mmf_mode_ctrl_sva mmf_mode_ctrl_sva_i (.core_clk, .srst, .regWr, .regRd,
    .symPort, .rate100, .txReq, .miiTxEnRaw, .miiTxEn, .txGo, .heartbeatCheckEn, .carrier,
    .rxActive, .rxStart, .addrValid, .rxEnd, .rxAccept, .rxDeliver, .rxDiscard, .regAddr,
    .regWrData, .regRdData);

/* File: verification/tb_mmf_mode_ctrl.sv */
// bench for the mode control block with a medium model
// assumes 25 MHz core_clk and the plain strobe register port
`timescale 1ns/100ps
module tb_mmf_mode_ctrl;
    import mmf_pkg::*;
    logic core_clk, srst, regWr, regRd, symPort, rate100, txReq, miiTxEnRaw, backoffLoad;
    logic miiTxEn, txGo, heartbeatCheckEn, rxAccept, rxDeliver, rxDiscard;
    logic carrier, rxActive, rxStart, addrValid, perfectHit, hashHit, rxEnd, rxBad;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData;
    logic [BO_W-1:0] backoffSlots;
    logic [47:0] rxDestAddr;
    int errors = 0;
    int checkCount = 0;
    int cyc = 0;
    // frame table: mode, filter setup, group, hit, hash, bad, deliver
    // last entry keeps promiscuous on beside bad-frame pass, as hosts should
    logic [15:0] ftab [10] = '{16'h4001, 16'h0000, 16'h0009, 16'h8011, 16'h8000,
                               16'h080B, 16'h000A, 16'h00C5, 16'h0021, 16'h4803};
    mmf_mode_ctrl mmf_mode_ctrl_i (.core_clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .symPort, .rate100, .txReq, .miiTxEnRaw, .miiTxEn, .txGo,
        .heartbeatCheckEn, .carrier, .rxActive, .backoffLoad, .backoffSlots, .rxStart,
        .addrValid, .rxDestAddr, .perfectHit, .hashHit, .rxEnd, .rxBad, .rxAccept,
        .rxDeliver, .rxDiscard);
    mmf_medium mmf_medium_i (.core_clk, .carrier, .rxActive, .rxStart, .addrValid,
        .perfectHit, .hashHit, .rxEnd, .rxBad, .rxDestAddr);
    ////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // hang guard, well above the few hundred cycles used
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) {regAddr, regWrData, regWr} <= {a, d, 1'b1};
        @(posedge core_clk) regWr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk) {regAddr, regRd} <= {a, 1'b1};
        @(posedge core_clk) regRd <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    // duplex set only with both start bits zero, loopback normal
    task automatic dpx(input logic d);
        wr(OPMODE_ADDR, 32'(d) << DUPLEX_BIT);
        fork
            mmf_medium_i.busy(8, 1'b1);
            begin
                repeat (4) @(posedge core_clk);
                #1 chk(txGo, d);
                chk(heartbeatCheckEn, !d);
            end
        join
    endtask
    task automatic waitGo(output int n);
        n = 0;
        // let the launching edge settle before the first look
        #1;
        while (txGo !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    initial begin
        int n;
        {regWr, regRd, symPort, rate100, txReq, miiTxEnRaw, backoffLoad} = 7'h00;
        {regAddr, regWrData, backoffSlots} = '0;
        srst = 1'b1;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        rc(OPMODE_ADDR, OPMODE_RESET);
        rc(8'h40, 32'h0);
        wr(OPMODE_ADDR, 32'h0000_00BC);
        rc(OPMODE_ADDR, 32'h0000_00A8);
        wr(FILTSET_ADDR, 32'h7);
        rc(OPMODE_ADDR, 32'h0000_00BD);
        $display("register test done");
        @(posedge core_clk) miiTxEnRaw <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(OPMODE_ADDR, 32'(c) << LOOP_LO);
            for (int s = 0; s < 2; s++) begin
                @(posedge core_clk) symPort <= s[0];
                #1 chk(miiTxEn, !(c == 1 && s == 0));
            end
        end
        @(posedge core_clk) txReq <= 1'b1;
        dpx(1'b1);
        dpx(1'b0);
        $display("loopback and duplex test done");
        for (int k = 0; k < 10; k++) begin
            wr(OPMODE_ADDR, {24'h0, ftab[k][15:8]});
            wr(FILTSET_ADDR, {29'h0, ftab[k][7:5]});
            mmf_medium_i.frame(ftab[k][4], ftab[k][3], ftab[k][2], ftab[k][1]);
            #1 chk(rxDeliver, ftab[k][0]);
            chk(rxDiscard, !ftab[k][0]);
        end
        wr(OPMODE_ADDR, OPMODE_RESET);
        wr(FILTSET_ADDR, 32'h0);
        fork
            mmf_medium_i.frame(1'b0, 1'b0, 1'b0, 1'b0);
            begin
                repeat (2) @(posedge core_clk);
                wr(OPMODE_ADDR, 32'h0);
            end
        join
        #1 chk(rxDeliver, 1'b1);
        // eleven frames so far: eight delivered, three dropped
        rc(STATUS_ADDR, 32'h0003_0008);
        $display("filter test done");
        fork
            mmf_medium_i.busy(30, 1'b0);
            begin
                @(posedge core_clk) {backoffLoad, backoffSlots} <= {1'b1, 10'h004};
                @(posedge core_clk) backoffLoad <= 1'b0;
                waitGo(n);
                chk(n, 32'h0000_0004);
            end
        join
        for (int r = 0; r < 2; r++) begin
            @(posedge core_clk) {txReq, rate100} <= {1'b0, r[0]};
            wr(OPMODE_ADDR, 32'h20);
            mmf_medium_i.busy(10, 1'b0);
            txReq <= 1'b1;
            waitGo(n);
            chk(n >= (r ? HOLD100_CYC : HOLD10_CYC) && n < 300, 1'b1);
        end
        $display("backoff test done");
        end_sim();
    end
endmodule
